// >>> hdl/ivp_top.sv
// Request line map, level registers and vector fetch for the CPU core.
// Assumes level-held peripheral requests and an AHB-Lite master on hclk.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module ivp_top
  import ivp_pkg::*;
#(
  parameter int N_LINES = 24
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ivp_src_s src,
  input wire logic cpu_ack,
  output logic [23:0] req_r,
  output ivp_vec_s vec_r
);

  // The source map is fixed to the documented line count
  if (N_LINES != IVP_NLINES) begin : g_chk
    $error("ivp_top: N_LINES must be 24");
  end

  // Bus-side state
  logic wr_pend_r, wr_pend_nxt;         // Write data phase pending
  logic [11:0] wr_addr_r, wr_addr_nxt;  // Latched write address
  logic [31:0] rdata_r, rdata_nxt;      // Read data for the data phase
  logic [7:0] lvl_r [IVP_NLVL];         // Level registers
  logic [7:0] lvl_nxt [IVP_NLVL];
  logic vwe;                            // Vector table write strobe
  logic [4:0] vwaddr;                   // Vector table write line

  // Request side state
  logic [23:0] req_w;                   // Mapped request lines
  logic [23:0] req_nxt;
  logic any_w;                          // Some line requests
  logic [4:0] win_w;                    // Winning line
  logic [1:0] win_lvl_w;                // Its level
  ivp_fsm_e st_r, st_nxt;               // Acknowledge sequencer
  logic [4:0] ack_line_r, ack_line_nxt; // Line taken at acknowledge
  logic [1:0] ack_lvl_r, ack_lvl_nxt;   // Level taken at acknowledge
  ivp_vec_s vec_nxt;
  logic [15:0] mem_rdata;               // Vector word from the store
  logic mem_re;                         // Store read strobe

  // Level field of one line
  function automatic logic [1:0] lvl_of(input logic [7:0] r [IVP_NLVL],
                                        input int n);
    lvl_of = r[n / 4][2 * (n % 4) +: 2];
  endfunction

  // Address-phase decode of a valid transfer
  logic take;
  assign take = hsel && hready && htrans == IVP_HTRANS_NONSEQ;

  // Map peripheral requests onto numbered lines
  always_comb begin
    req_w = '0;
    req_w[0] = src.ext_int[0] | src.ext_int[4];
    req_w[1] = src.ext_int[1] | src.ext_int[5];
    req_w[2] = src.ext_int[2] | src.ext_int[6];
    req_w[3] = src.ext_int[3] | src.ext_int[7];
    req_w[4] = src.uart;
    req_w[5] = src.tmr_lo;
    req_w[6] = src.tmr_hi;
    req_w[7] = src.ocmp[0];
    req_w[8] = src.ocmp[1];
    req_w[13:10] = src.vcmp;
    req_w[14] = |src.frt;
    req_w[15] = src.pulse_generator;
    req_w[16] = src.i2c;
    req_w[18] = src.adc;
    req_w[19] = src.tbt;
    req_w[20] = src.wpre;
    req_w[23] = src.flash;
  end

  // Pick the winner: lower level value first, then lower line number
  always_comb begin
    any_w = 1'b0;
    win_w = 5'h00;
    win_lvl_w = 2'h3;
    for (int n = IVP_NLINES - 1; n >= 0; n--) begin
      // Walking downward with <= lets the lower line take a tie
      if (req_w[n] && (!any_w || lvl_of(lvl_r, n) <= win_lvl_w)) begin
        any_w = 1'b1;
        win_w = 5'(n);
        win_lvl_w = lvl_of(lvl_r, n);
      end
    end
  end

  // Bus next state: read data, write capture, level register updates
  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = '0;
    lvl_nxt = lvl_r;
    vwe = 1'b0;
    vwaddr = wr_addr_r[6:2];
    // Data phase of a write
    if (wr_pend_r) begin
      for (int i = 0; i < IVP_NLVL; i++) begin
        if (wr_addr_r == {2'b00, IVP_LVL_IDX0 + 8'(i), 2'b00}) begin
          lvl_nxt[i] = hwdata[7:0];
        end
      end
      if (wr_addr_r >= IVP_VEC_BASE && wr_addr_r[6:2] < 5'(IVP_NLINES)
          && wr_addr_r[11:7] == IVP_VEC_BASE[11:7]) begin
        vwe = 1'b1;
      end
    end
    // Address phase
    if (take) begin
      if (hwrite) begin
        wr_pend_nxt = 1'b1;
        wr_addr_nxt = haddr[11:0];
      end else begin
        // Status read shows live requests, winner and any-request flag
        if (haddr[11:0] == IVP_STAT_ADDR) begin
          rdata_nxt = {any_w, 2'b00, win_w, req_w};
        end
        for (int i = 0; i < IVP_NLVL; i++) begin
          if (haddr[11:0] == {2'b00, IVP_LVL_IDX0 + 8'(i), 2'b00}) begin
            rdata_nxt = {24'h000000, lvl_r[i]};
          end
        end
      end
    end
  end

  // Bus state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rdata_r <= '0;
      for (int i = 0; i < IVP_NLVL; i++) begin
        lvl_r[i] <= IVP_LVL_RST;
      end
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // Zero wait states and OKAY always; these stay constant flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = rdata_r;

  // Vector word store, written from the bus, read on acknowledge
  ivp_vec_mem #(
    .W(16),
    .DEPTH(IVP_NLINES),
    .AW(5)
  ) u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(vwe),
    .waddr(vwaddr),
    .wdata(hwdata[15:0]),
    .re(mem_re),
    .raddr(win_w),
    .rdata_r(mem_rdata)
  );

  // Acknowledge sequencer: take the winner, read its vector, present it
  always_comb begin
    st_nxt = st_r;
    ack_line_nxt = ack_line_r;
    ack_lvl_nxt = ack_lvl_r;
    mem_re = 1'b0;
    vec_nxt = vec_r;
    vec_nxt.valid = 1'b0;
    req_nxt = req_w;
    unique case (st_r)
      IVP_IDLE: begin
        // An acknowledge with nothing pending is ignored
        if (cpu_ack && any_w) begin
          mem_re = 1'b1;
          ack_line_nxt = win_w;
          ack_lvl_nxt = win_lvl_w;
          st_nxt = IVP_FETCH;
        end
      end
      IVP_FETCH: begin
        // Upper byte at the even address, lower at the next odd one
        vec_nxt.valid = 1'b1;
        vec_nxt.line = ack_line_r;
        vec_nxt.level = ack_lvl_r;
        vec_nxt.vaddr = ivp_vaddr(ack_line_r);
        vec_nxt.vector = mem_rdata;
        st_nxt = IVP_IDLE;
      end
    endcase
  end

  // Sequencer and output registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= IVP_IDLE;
      ack_line_r <= '0;
      ack_lvl_r <= '0;
      vec_r <= '0;
      req_r <= '0;
    end else begin
      st_r <= st_nxt;
      ack_line_r <= ack_line_nxt;
      ack_lvl_r <= ack_lvl_nxt;
      vec_r <= vec_nxt;
      req_r <= req_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Source map: each line follows its sources one cycle later
  AST_LINE0: assert property (##1 req_r[0] ==
                              ($past(src.ext_int[0]) | $past(src.ext_int[4])))
    else $error("line 0 not channels 0 or 4");
  AST_LINE1: assert property (src.ext_int[5] |=> req_r[1])
    else $error("channel 5 did not raise line 1");
  AST_LINE2: assert property (src.ext_int[2] |=> req_r[2])
    else $error("channel 2 did not raise line 2");
  AST_LINE3: assert property (src.ext_int[7] |=> req_r[3])
    else $error("channel 7 did not raise line 3");
  AST_LINE456: assert property (##1 req_r[6:4] ==
                                {$past(src.tmr_hi), $past(src.tmr_lo), $past(src.uart)})
    else $error("serial or timer line missing");
  AST_LINE7: assert property (##1 req_r[7] == $past(src.ocmp[0]))
    else $error("line 7 not compare 0");
  AST_LINE8: assert property (##1 req_r[8] == $past(src.ocmp[1]))
    else $error("line 8 not compare 1");
  AST_VCMP: assert property (##1 req_r[13:10] == $past(src.vcmp))
    else $error("comparator lines wrong");
  AST_FRT: assert property (##1 req_r[14] == |$past(src.frt))
    else $error("line 14 not timer events");
  // Arbitration, unused lines and level registers
  AST_TIE: assert property (any_w && req_w[win_w] |-> !(win_w > 0 && req_w[0]
                            && lvl_of(lvl_r, 0) <= win_lvl_w))
    else $error("line 0 lost a tie");
  AST_UNUSED: assert property (req_r[9] == 1'b0 && req_r[17] == 1'b0
                               && req_r[22:21] == 2'h0)
    else $error("unused line raised");
  AST_LVLRST: assert property ($rose(hresetn) |-> lvl_r[5] == IVP_LVL_RST)
    else $error("level register not ones after reset");
  // Acknowledge answer timing
  AST_ACKVEC: assert property (st_r == IVP_IDLE && cpu_ack && any_w
                               |-> ##2 vec_r.valid && vec_r.line == $past(win_w, 2)
                               && vec_r.vaddr == ivp_vaddr($past(win_w, 2)))
    else $error("vector not presented two cycles after acknowledge");

  // Source map: remaining sources each raise their own line
  AST_PG: assert property (src.pulse_generator |=> req_r[15])
    else $error("pulse generator did not raise line 15");
  AST_I2C: assert property (src.i2c |=> req_r[16])
    else $error("two-wire unit did not raise line 16");
  AST_ADC: assert property (src.adc |=> req_r[18])
    else $error("converter did not raise line 18");
  AST_TBT: assert property (src.tbt |=> req_r[19])
    else $error("time-base timer did not raise line 19");
  AST_WPRE: assert property (src.wpre |=> req_r[20])
    else $error("watch prescaler did not raise line 20");
  AST_FLASH: assert property (src.flash |=> req_r[23])
    else $error("flash memory did not raise line 23");
  // Channel 4 shares line 0 with channel 0
  AST_LINE0B: assert property (src.ext_int[4] |=> req_r[0])
    else $error("channel 4 did not raise line 0");

  // Arbitration: the winner requests and carries its own level
  AST_WINREQ: assert property (any_w |-> req_w[win_w]
                               && win_lvl_w == lvl_of(lvl_r, int'(win_w)))
    else $error("winner not a requesting line");
  // No request, no winner
  AST_NONE: assert property (req_w == 24'h000000 |-> !any_w)
    else $error("winner flagged with no request");

  // Bus answer: no wait states and always OKAY
  AST_RDY: assert property (hreadyout == 1'b1)
    else $error("bus answer not ready");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("bus answer not OKAY");
  // Read data stands one cycle and is zero unless a read was taken
  AST_RD_IDLE: assert property (!(take && !hwrite) |=> hrdata == 32'h00000000)
    else $error("read data left standing");
  // A level write lands at the edge that closes its data phase
  AST_LVLWR0: assert property (wr_pend_r
                               && wr_addr_r == {2'b00, IVP_LVL_IDX0, 2'b00}
                               |=> lvl_r[0] == $past(hwdata[7:0]))
    else $error("level register 0 write lost");
  AST_LVLWR5: assert property (wr_pend_r
                               && wr_addr_r == {2'b00, IVP_LVL_IDX5, 2'b00}
                               |=> lvl_r[5] == $past(hwdata[7:0]))
    else $error("level register 5 write lost");

  // Answer: a one-cycle pulse naming the upper byte address of its line
  AST_VPULSE: assert property (vec_r.valid |=> !vec_r.valid)
    else $error("vector answer longer than one cycle");
  AST_VADDR: assert property (vec_r.valid |->
                              vec_r.vaddr == IVP_VEC_TOP - {10'h000, vec_r.line, 1'b0})
    else $error("vector address not the line's upper byte address");
  // An acknowledge with nothing pending starts no fetch
  AST_NOACK: assert property (st_r == IVP_IDLE && cpu_ack && !any_w
                              |=> st_r == IVP_IDLE && !vec_r.valid)
    else $error("acknowledge without request started a fetch");

  // Coverage of the main scenarios
  COV_ACK: cover property (cpu_ack && any_w ##2 vec_r.valid);
  COV_TIE: cover property (req_w[0] && req_w[23] && win_w == 5'h00);
  COV_LVLWR: cover property (wr_pend_r && lvl_nxt[0] != lvl_r[0]);
  COV_NOACK: cover property (st_r == IVP_IDLE && cpu_ack && !any_w);
  COV_LVLWIN: cover property (vec_r.valid && vec_r.line == 5'h17 && vec_r.level == 2'h0);

endmodule // ivp_top

// >>> hdl/ivp_pkg.sv
// Package for the interrupt request map and vectoring block.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
package ivp_pkg;

  // Number of request lines
  localparam int IVP_NLINES = 24;
  // Level register printed indices; byte address is four times the index
  localparam logic [7:0] IVP_LVL_IDX0 = 8'h79;
  localparam logic [7:0] IVP_LVL_IDX1 = 8'h7a;
  localparam logic [7:0] IVP_LVL_IDX2 = 8'h7b;
  localparam logic [7:0] IVP_LVL_IDX3 = 8'h7c;
  localparam logic [7:0] IVP_LVL_IDX4 = 8'h7d;
  localparam logic [7:0] IVP_LVL_IDX5 = 8'h7e;
  localparam int IVP_NLVL = 6;
  // Level register value after reset
  localparam logic [7:0] IVP_LVL_RST = 8'hff;
  // Status register and vector table window byte addresses
  localparam logic [11:0] IVP_STAT_ADDR = 12'h000;
  localparam logic [11:0] IVP_VEC_BASE = 12'h400;
  // Upper byte address of line 0's vector; each later line sits two lower
  localparam logic [15:0] IVP_VEC_TOP = 16'hfffa;
  // AHB transfer type for a single transfer
  localparam logic [1:0] IVP_HTRANS_NONSEQ = 2'h2;
  // Cycles from an accepted acknowledge to the vector output
  localparam int IVP_ACK_LAT = 2;

  // Peripheral request sources
  typedef struct packed {
    logic [7:0] ext_int;      // External interrupt channels 0..7
    logic uart;               // UART / sync_serial_unit
    logic tmr_lo;             // Composite timer lower half
    logic tmr_hi;             // Composite timer upper half
    logic [1:0] ocmp;         // Output compare match 0..1
    logic [3:0] vcmp;         // Voltage comparators 0..3
    logic [2:0] frt;          // Free-running timer match, zero, overflow
    logic pulse_generator;    // Pulse generator
    logic i2c;                // I2C unit
    logic adc;                // A/D converter
    logic tbt;                // Time-base timer
    logic wpre;               // Watch prescaler
    logic flash;              // Flash memory
  } ivp_src_s;

  // Vector answer to the CPU core
  typedef struct packed {
    logic valid;              // One-cycle pulse with the fields below
    logic [4:0] line;         // Winning request line
    logic [1:0] level;        // Its level field
    logic [15:0] vaddr;       // Upper byte address of its vector
    logic [15:0] vector;      // Fetched vector
  } ivp_vec_s;

  // Acknowledge sequencer states
  typedef enum logic [0:0] {IVP_IDLE, IVP_FETCH} ivp_fsm_e;

  // Upper byte address of a line's vector; lower byte is the next address
  function automatic logic [15:0] ivp_vaddr(input logic [4:0] line);
    ivp_vaddr = IVP_VEC_TOP - {10'h000, line, 1'b0};
  endfunction

endpackage

// >>> hdl/ivp_vec_mem.sv
// Vector word store for the request lines, one 16-bit word per line.
// Assumes one writer and one reader in the same clock domain.
`timescale 1ns/1ps
module ivp_vec_mem #(
  parameter int W = 16,
  parameter int DEPTH = 24,
  parameter int AW = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_r
);

  // Refuse shapes the address cannot reach
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
    $error("ivp_vec_mem: DEPTH does not fit AW");
  end

  logic [W-1:0] mem_r [DEPTH]; // Storage words

  // Write port and registered read port; words clear on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rdata_r <= '0;
    end else begin
      if (we && int'(waddr) < DEPTH) begin
        mem_r[waddr] <= wdata;
      end
      if (re && int'(raddr) < DEPTH) begin
        rdata_r <= mem_r[raddr];
      end
    end
  end

endmodule // ivp_vec_mem

// >>> bench/ivp_cpu_model.sv
// CPU core model: pulses the acknowledge and takes the vector answer.
// Assumes the block answers exactly two edges after it takes the pulse.
`timescale 1ns/1ps
module ivp_cpu_model
  import ivp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire ivp_vec_s vec_r,
  output logic cpu_ack
);
  // Acknowledge idles low outside a fetch
  initial cpu_ack = 1'b0;

  // One fetch; gap idle cycles first models a slow core
  task automatic fetch(input int gap, output ivp_vec_s got, output logic seen);
    logic early;
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    cpu_ack <= 1'b1;
    @(posedge hclk);
    cpu_ack <= 1'b0;
    #1;
    early = vec_r.valid;
    @(posedge hclk);
    #1;
    // Vector taken whole, upper and lower byte together
    got = vec_r;
    seen = vec_r.valid & ~early;
    // The answer is a one-cycle pulse: it must be gone one edge later
    @(posedge hclk);
    #1;
    seen = seen & ~vec_r.valid;
  endtask
endmodule // ivp_cpu_model

// >>> bench/ivp_tb.sv
// Testbench for the request map, level registers and vector fetch.
// Assumes the package, the design and the CPU model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module interrupt_vector_priority_map_tb_top;
  import ivp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_ack, seen;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [23:0] req_r;
  ivp_src_s src, s;
  ivp_vec_s vec_r, got;
  int err_total, checks_done, cyc;
  // Line expected for each source bit, counted from the lsb of the struct
  int exp_line [26] = '{23, 20, 19, 18, 16, 15, 14, 14, 14, 10, 11, 12, 13, 7, 8, 6, 5, 4,
    0, 1, 2, 3, 0, 1, 2, 3};

  ivp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src(src), .cpu_ack(cpu_ack),
    .req_r(req_r), .vec_r(vec_r));
  ivp_cpu_model u_cpu (.hclk(hclk), .hresetn(hresetn), .vec_r(vec_r), .cpu_ack(cpu_ack));

  // Clock, 40 ns period
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Byte address of a level register
  function automatic logic [31:0] lvl_addr(input int k);
    return 32'((int'(IVP_LVL_IDX0) + k) * 4);
  endfunction

  // Single AHB write: address phase, then data phase
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= IVP_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // Single AHB read; data taken at the data phase's closing edge
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= IVP_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish;
    end
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    src = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Level registers: reset value, write and read back, restore
    for (int k = 0; k < IVP_NLVL; k++) begin
      bus_rd(lvl_addr(k), rd);
      `CHK("lvl_rst", {24'h0, IVP_LVL_RST}, rd)
      `CHK("hresp", 1'b0, hresp)
      bus_wr(lvl_addr(k), 32'hffff_ff00 | 32'(k * 17 + 64));
      bus_rd(lvl_addr(k), rd);
      `CHK("lvl_rw", 32'(k * 17 + 64), rd)
      bus_wr(lvl_addr(k), 32'h0000_00ff);
    end
    // Unmapped place ignores writes and reads zero
    bus_wr(32'h200, 32'hffff_ffff);
    bus_rd(32'h200, rd);
    `CHK("unmapped", 32'h0, rd)
    // Vector store: upper byte a5, lower byte the line number
    for (int l = 0; l < IVP_NLINES; l++) begin
      bus_wr(32'h400 + 32'(4 * l), 32'h0000_a500 + 32'(l));
    end
    bus_rd(32'h404, rd);
    `CHK("vec_window", 32'h0, rd)
    // Each source alone: mapped line, then a fetch of its vector
    for (int k = 0; k < $bits(ivp_src_s); k++) begin
      @(posedge hclk);
      src <= ivp_src_s'(26'(1) << k);
      repeat (2) @(posedge hclk);
      #1;
      `CHK("req_line", 24'(1) << exp_line[k], req_r)
      `CHK("req_map", 24'(1) << exp_line[k], req_r)
      u_cpu.fetch((k % 2) * 3, got, seen);
      `CHK("ack_seen", 1'b1, seen)
      `CHK("win_line", 5'(exp_line[k]), got.line)
      `CHK("vaddr", 16'(16'hfffa - 2 * exp_line[k]), got.vaddr)
      `CHK("vector", 16'(16'ha500 + exp_line[k]), got.vector)
      `CHK("level", 2'h3, got.level)
    end
    // Equal level: lowest line wins; status shows lines and winner
    s = '0;
    s.ext_int[4] = 1'b1;
    s.ext_int[7] = 1'b1;
    s.flash = 1'b1;
    @(posedge hclk);
    src <= s;
    repeat (2) @(posedge hclk);
    bus_rd(32'h0, rd);
    `CHK("status", 32'h8080_0009, rd)
    u_cpu.fetch(0, got, seen);
    `CHK("tie_line", 5'd0, got.line)
    // Line 23 raised to level 0 now beats lines 0 and 3
    bus_wr(lvl_addr(5), 32'h0000_003f);
    u_cpu.fetch(1, got, seen);
    `CHK("lvl_line", 5'd23, got.line)
    `CHK("lvl_val", 2'h0, got.level)
    `CHK("lvl_vec", 16'ha517, got.vector)
    `CHK("lvl_vaddr", 16'hffcc, got.vaddr)
    // Acknowledge with nothing pending is dropped
    @(posedge hclk);
    src <= '0;
    repeat (2) @(posedge hclk);
    u_cpu.fetch(0, got, seen);
    `CHK("no_req", 1'b0, seen)
    tally_and_finish;
  end
endmodule // interrupt_vector_priority_map_tb_top
